/* File: shared/pifl_defs.vh */
// Offsets, field positions, masks, reset values and vectors for the interrupt flag logic
// Function
// - Reset control bit 7 enables priority levels
// - Unimplemented flag/enable/priority bits read zero
// - Conversion-done flag sets, software clears
// - Receive flag mirrors buffer full, read-only
// - Transmit flag mirrors holding empty, read-only
// - Sync port flag sets on completion
// - Capture/compare flags set per mode
// - Timer2 period match sets flag
// - Timer1 overflow sets flag
// - Bus collision sets second-register flag
// - Low voltage trip sets flag
// - Timer3 overflow sets flag
// - Enable bits gate sources, reset zero
// - Priority bits select level, reset one
// - External pins edge-detected, selectable polarity
// - Selected edge sets pin flag
// - Enabled pin flag wakes the processor
// - Pin 0 always high priority
// - Timer0 rollover sets its flag
// - Port B upper change sets flag
// - Priority mode vectors 000008h or 000018h
// - Compatibility mode always vectors 000008h
// - Flags set regardless of enables
// - Compatibility needs peripheral group enable
`ifndef PIFL_DEFS_VH
`define PIFL_DEFS_VH
// Register byte addresses (word aligned)
`define PIFL_OFS_RESET_CONTROL_STATUS     12'h000
`define PIFL_OFS_FLAGS_A  12'h004
`define PIFL_OFS_FLAGS_B  12'h008
`define PIFL_OFS_ENA_A    12'h00c
`define PIFL_OFS_ENA_B    12'h010
`define PIFL_OFS_PRIO_A   12'h014
`define PIFL_OFS_PRIO_B   12'h018
`define PIFL_OFS_CORE     12'h01c
`define PIFL_OFS_EXT      12'h020
`define PIFL_OFS_VECTOR   12'h024
// Field positions
`define PIFL_BIT_PRIO_ON  7
`define PIFL_BIT_AD       6
`define PIFL_BIT_RX       5
`define PIFL_BIT_TX       4
`define PIFL_BIT_SYNC     3
`define PIFL_BIT_CCPA     2
`define PIFL_BIT_TMR2     1
`define PIFL_BIT_TMR1     0
`define PIFL_BIT_BCOL     3
`define PIFL_BIT_LVD      2
`define PIFL_BIT_TMR3     1
`define PIFL_BIT_CCPB     0
// Core control register fields
`define PIFL_BIT_GLOBAL_HIGH_ENABLE     7
`define PIFL_BIT_GLOBAL_LOW_ENABLE     6
`define PIFL_BIT_T0E      5
`define PIFL_BIT_X0E      4
`define PIFL_BIT_PCE      3
`define PIFL_BIT_T0F      2
`define PIFL_BIT_X0F      1
`define PIFL_BIT_PCF      0
// Implemented masks and reset values
`define PIFL_MASK_A       8'h7f
`define PIFL_MASK_B       8'h0f
`define PIFL_MASK_RESET_CONTROL_STATUS    8'h9e
`define PIFL_RST_RESET_CONTROL_STATUS     8'h1c
`define PIFL_RST_PRIO_A   8'h7f
`define PIFL_RST_PRIO_B   8'h0f
`define PIFL_RST_EXT      8'h7c
`define PIFL_RST_CPRIO    2'h3
// Vectors
`define PIFL_VEC_HIGH     24'h000008
`define PIFL_VEC_LOW      24'h000018
`endif

/* File: hdl/pifl_edge.v */
// Synchroniser and selectable edge detector for one external pin
`timescale 1ns/10ps
`default_nettype none
module pifl_edge (
	input  wire clock,
	input  wire nrst,
	input  wire pin,
	input  wire rising_sel,
	output wire edge_seen
);
	reg sync_a;
	reg sync_b;
	reg last;

	// Two stages before use; only sync_b feeds logic
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			last   <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			last   <= sync_b;
		end
	end

	// Polarity chosen by the edge select bit
	assign edge_seen = rising_sel ? (sync_b & ~last) : (~sync_b & last);
endmodule
`default_nettype wire

/* File: hdl/pifl_top.v */
// Prioritized interrupt flag logic with APB register access
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pifl_defs.vh"
module pifl_top (
	input  wire        clock,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        analog_conv_done,
	input  wire        serial_rx_full,
	input  wire        serial_tx_empty,
	input  wire        sync_port_done,
	input  wire [1:0]  capcomp_mode_pwm,
	input  wire [1:0]  capcomp_capture_event,
	input  wire [1:0]  capcomp_compare_event,
	input  wire        timer2_period_match,
	input  wire        timer1_wrap,
	input  wire        bus_collision,
	input  wire        low_voltage_trip,
	input  wire        timer3_wrap,
	input  wire        timer0_wrap,
	input  wire [2:0]  ext_pin,
	input  wire [3:0]  port_b_upper,
	input  wire        port_b_read,
	input  wire        reset_instruction_evt,
	input  wire        watchdog_timeout_evt,
	input  wire        power_down_evt,
	input  wire        irq_taken,
	input  wire        irq_return,
	output reg         irq_high,
	output reg         irq_low,
	output reg         wake_request,
	output reg  [23:0] irq_vector
);
	// Control and status registers
	reg  [7:0] reset_control_status;
	reg  [7:0] periph_irq_flags_a;
	reg  [7:0] periph_irq_flags_b;
	reg  [7:0] periph_irq_enables_a;
	reg  [7:0] periph_irq_enables_b;
	reg  [7:0] periph_irq_priority_a;
	reg  [7:0] periph_irq_priority_b;
	reg  [7:0] core_ctrl;
	reg  [7:0] ext_ctrl;
	reg  [1:0] core_prio;
	reg        ext_pin1_flag;
	reg  [3:0] port_sync_a;
	reg  [3:0] port_sync_b;
	reg  [3:0] port_snapshot;
	reg  [1:0] evt_sync_a;
	reg  [1:0] evt_sync_b;
	wire [2:0] ext_edge;
	wire       wr_en;
	wire       rd_en;
	wire [7:0] wbyte;
	wire       priority_levels_on;
	wire       global_high_enable;
	wire       global_low_enable;
	wire [7:0] set_a;
	wire [3:0] set_b;
	wire       port_mismatch;
	wire [2:0] ext_pin_enable;
	wire [2:0] ext_pin_flag;
	wire [2:0] ext_pin_prio;
	wire       ext_pin1_priority;
	wire       ext_pin2_priority;
	reg        next_irq_high;
	reg        next_irq_low;

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, unmapped offsets answer with an error

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign wbyte   = pwdata[7:0];
	assign pslverr = psel & penable & (paddr > `PIFL_OFS_VECTOR || paddr[1:0] != 2'b00);

	// Extended pin control bits: edge selects 6:4, pin priorities 3:2, enables 1:0
	assign ext_pin1_priority = ext_ctrl[2];
	assign ext_pin2_priority = ext_ctrl[3];
	assign ext_pin_enable    = {ext_ctrl[1], ext_ctrl[0], core_ctrl[`PIFL_BIT_X0E]};
	assign ext_pin_flag      = {ext_ctrl[7], ext_pin1_flag, core_ctrl[`PIFL_BIT_X0F]};
	assign priority_levels_on = reset_control_status[`PIFL_BIT_PRIO_ON];
	assign global_high_enable = core_ctrl[`PIFL_BIT_GLOBAL_HIGH_ENABLE];
	assign global_low_enable  = core_ctrl[`PIFL_BIT_GLOBAL_LOW_ENABLE];

	////////////////////////////////////////////////////////////////////////
	// External pin edge detectors, one per pin

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
			pifl_edge u_edge (
				.clock      (clock),
				.nrst       (nrst),
				.pin        (ext_pin[gi]),
				.rising_sel (ext_ctrl[4 + gi]),
				.edge_seen  (ext_edge[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Port B change detection against the value latched on the last read

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			port_sync_a   <= 4'h0;
			port_sync_b   <= 4'h0;
			port_snapshot <= 4'h0;
		end else begin
			port_sync_a <= port_b_upper;
			port_sync_b <= port_sync_a;
			if (port_b_read)
				port_snapshot <= port_sync_b; // Reading ends the mismatch
		end
	end

	assign port_mismatch = |(port_sync_b ^ port_snapshot);

	////////////////////////////////////////////////////////////////////////
	// Peripheral event sets; events come from same-clock logic

	assign set_a[7]              = 1'b0;
	assign set_a[`PIFL_BIT_AD]   = analog_conv_done;
	assign set_a[`PIFL_BIT_RX]   = 1'b0;
	assign set_a[`PIFL_BIT_TX]   = 1'b0;
	assign set_a[`PIFL_BIT_SYNC] = sync_port_done;
	assign set_a[`PIFL_BIT_CCPA] = ~capcomp_mode_pwm[0] &
		(capcomp_capture_event[0] | capcomp_compare_event[0]);
	assign set_a[`PIFL_BIT_TMR2] = timer2_period_match;
	assign set_a[`PIFL_BIT_TMR1] = timer1_wrap;
	assign set_b[`PIFL_BIT_BCOL] = bus_collision;
	assign set_b[`PIFL_BIT_LVD]  = low_voltage_trip;
	assign set_b[`PIFL_BIT_TMR3] = timer3_wrap;
	assign set_b[`PIFL_BIT_CCPB] = ~capcomp_mode_pwm[1] &
		(capcomp_capture_event[1] | capcomp_compare_event[1]);

	////////////////////////////////////////////////////////////////////////
	// Register file; sets override software clears in the same cycle

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reset_control_status  <= `PIFL_RST_RESET_CONTROL_STATUS;
			periph_irq_flags_a    <= 8'h00;
			periph_irq_flags_b    <= 8'h00;
			periph_irq_enables_a  <= 8'h00;
			periph_irq_enables_b  <= 8'h00;
			periph_irq_priority_a <= `PIFL_RST_PRIO_A;
			periph_irq_priority_b <= `PIFL_RST_PRIO_B;
			core_ctrl             <= 8'h00;
			ext_ctrl              <= `PIFL_RST_EXT;
			evt_sync_a            <= 2'b00;
			evt_sync_b            <= 2'b00;
		end else begin
			// Status events from another reset domain pass two stages
			evt_sync_a <= {watchdog_timeout_evt, power_down_evt};
			evt_sync_b <= evt_sync_a;
			if (wr_en && paddr == `PIFL_OFS_RESET_CONTROL_STATUS)
				reset_control_status <= (wbyte & `PIFL_MASK_RESET_CONTROL_STATUS) |
					(reset_control_status & 8'h1c & ~wbyte & 8'h00);
			if (reset_instruction_evt)
				reset_control_status[4] <= 1'b0;
			if (evt_sync_b[1])
				reset_control_status[3] <= 1'b0;
			if (evt_sync_b[0])
				reset_control_status[2] <= 1'b0;
			// Flags: software write, then hardware set wins
			if (wr_en && paddr == `PIFL_OFS_FLAGS_A)
				periph_irq_flags_a <= wbyte & 8'h4f;
			else
				periph_irq_flags_a <= periph_irq_flags_a | set_a;
			if (wr_en && paddr == `PIFL_OFS_FLAGS_A)
				periph_irq_flags_a[3:0] <= (wbyte[3:0]) | set_a[3:0];
			if (wr_en && paddr == `PIFL_OFS_FLAGS_A)
				periph_irq_flags_a[6] <= wbyte[6] | set_a[6];
			if (wr_en && paddr == `PIFL_OFS_FLAGS_B)
				periph_irq_flags_b <= (wbyte & `PIFL_MASK_B) | {4'h0, set_b};
			else
				periph_irq_flags_b <= periph_irq_flags_b | {4'h0, set_b};
			if (wr_en && paddr == `PIFL_OFS_ENA_A)
				periph_irq_enables_a <= wbyte & `PIFL_MASK_A;
			if (wr_en && paddr == `PIFL_OFS_ENA_B)
				periph_irq_enables_b <= wbyte & `PIFL_MASK_B;
			if (wr_en && paddr == `PIFL_OFS_PRIO_A)
				periph_irq_priority_a <= wbyte & `PIFL_MASK_A;
			if (wr_en && paddr == `PIFL_OFS_PRIO_B)
				periph_irq_priority_b <= wbyte & `PIFL_MASK_B;
			// Core control: global enables, timer0, pin 0, port change
			if (wr_en && paddr == `PIFL_OFS_CORE)
				core_ctrl <= wbyte;
			if (irq_taken) begin
				// Entering a handler drops the global enable that admitted it
				if (!priority_levels_on || next_irq_high)
					core_ctrl[`PIFL_BIT_GLOBAL_HIGH_ENABLE] <= 1'b0;
				else
					core_ctrl[`PIFL_BIT_GLOBAL_LOW_ENABLE] <= 1'b0;
			end else if (irq_return) begin
				if (!priority_levels_on || !global_high_enable)
					core_ctrl[`PIFL_BIT_GLOBAL_HIGH_ENABLE] <= 1'b1;
				else
					core_ctrl[`PIFL_BIT_GLOBAL_LOW_ENABLE] <= 1'b1;
			end
			if (timer0_wrap)
				core_ctrl[`PIFL_BIT_T0F] <= 1'b1;
			if (ext_edge[0])
				core_ctrl[`PIFL_BIT_X0F] <= 1'b1;
			if (port_mismatch)
				core_ctrl[`PIFL_BIT_PCF] <= 1'b1;
			// Pin control: bit 7 pin2 flag, bit 6..4 edge selects, 3:2 prio, 1:0 en
			if (wr_en && paddr == `PIFL_OFS_EXT)
				ext_ctrl <= wbyte;
			if (ext_edge[2])
				ext_ctrl[7] <= 1'b1;
		end
	end

	// Timer0 and port-change priority bits, both high after reset; they sit in
	// write bits 2:1 of the vector word so that no pin bit has to be shared
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			core_prio <= `PIFL_RST_CPRIO;
		else if (wr_en && paddr == `PIFL_OFS_VECTOR)
			core_prio <= wbyte[2:1];
	end

	// Pin 1 flag reads back at bit 24 of the vector word, written through bit 0
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			ext_pin1_flag <= 1'b0;
		else if (ext_edge[1])
			ext_pin1_flag <= 1'b1;
		else if (wr_en && paddr == `PIFL_OFS_VECTOR)
			ext_pin1_flag <= wbyte[0];
	end

	// The receive and transmit flags are live mirrors, never stored
	wire [7:0] flags_a_view;
	assign flags_a_view = {1'b0, periph_irq_flags_a[6], serial_rx_full, serial_tx_empty,
		periph_irq_flags_a[3:0]};

	////////////////////////////////////////////////////////////////////////
	// Request formation and vectoring

	wire [7:0] act_a;
	wire [3:0] act_b;
	wire       hi_src;
	wire       lo_src;
	wire       periph_any;
	wire       core_any;
	assign act_a = flags_a_view & periph_irq_enables_a;
	assign act_b = periph_irq_flags_b[3:0] & periph_irq_enables_b[3:0];
	assign periph_any = |act_a | |act_b;
	assign core_any = (core_ctrl[`PIFL_BIT_T0F] & core_ctrl[`PIFL_BIT_T0E]) |
		(core_ctrl[`PIFL_BIT_X0F] & core_ctrl[`PIFL_BIT_X0E]) |
		(core_ctrl[`PIFL_BIT_PCF] & core_ctrl[`PIFL_BIT_PCE]) |
		(ext_pin1_flag & ext_pin_enable[1]) | (ext_pin_flag[2] & ext_pin_enable[2]);
	// Pin 0 has no priority bit and is always high
	assign hi_src = |(act_a & periph_irq_priority_a) |
		|(act_b & periph_irq_priority_b[3:0]) |
		(core_ctrl[`PIFL_BIT_X0F] & core_ctrl[`PIFL_BIT_X0E]) |
		(core_ctrl[`PIFL_BIT_T0F] & core_ctrl[`PIFL_BIT_T0E] & core_prio[0]) |
		(core_ctrl[`PIFL_BIT_PCF] & core_ctrl[`PIFL_BIT_PCE] & core_prio[1]) |
		(ext_pin1_flag & ext_pin_enable[1] & ext_pin1_priority) |
		(ext_pin_flag[2] & ext_pin_enable[2] & ext_pin2_priority);
	assign lo_src = |(act_a & ~periph_irq_priority_a) |
		|(act_b & ~periph_irq_priority_b[3:0]) |
		(core_ctrl[`PIFL_BIT_T0F] & core_ctrl[`PIFL_BIT_T0E] & ~core_prio[0]) |
		(core_ctrl[`PIFL_BIT_PCF] & core_ctrl[`PIFL_BIT_PCE] & ~core_prio[1]) |
		(ext_pin1_flag & ext_pin_enable[1] & ~ext_pin1_priority) |
		(ext_pin_flag[2] & ext_pin_enable[2] & ~ext_pin2_priority);

	// Compatibility mode folds every source onto the high line
	always @* begin
		if (priority_levels_on) begin
			next_irq_high = global_high_enable & hi_src;
			next_irq_low  = global_low_enable & lo_src & ~(global_high_enable & hi_src);
		end else begin
			next_irq_high = global_high_enable &
				(core_any | (global_low_enable & periph_any));
			next_irq_low  = 1'b0;
		end
	end

	// Outputs registered so the core sees clean levels
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq_high     <= 1'b0;
			irq_low      <= 1'b0;
			wake_request <= 1'b0;
			irq_vector   <= `PIFL_VEC_HIGH;
		end else begin
			irq_high     <= next_irq_high;
			irq_low      <= next_irq_low;
			wake_request <= core_any | periph_any;
			irq_vector   <= (priority_levels_on && !next_irq_high && next_irq_low) ?
				`PIFL_VEC_LOW : `PIFL_VEC_HIGH;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unimplemented bits are masked to zero

	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
			`PIFL_OFS_RESET_CONTROL_STATUS:    prdata <= {24'h000000, reset_control_status & `PIFL_MASK_RESET_CONTROL_STATUS};
			`PIFL_OFS_FLAGS_A: prdata <= {24'h000000, flags_a_view};
			`PIFL_OFS_FLAGS_B: prdata <= {24'h000000, periph_irq_flags_b & `PIFL_MASK_B};
			`PIFL_OFS_ENA_A:   prdata <= {24'h000000, periph_irq_enables_a};
			`PIFL_OFS_ENA_B:   prdata <= {24'h000000, periph_irq_enables_b};
			`PIFL_OFS_PRIO_A:  prdata <= {24'h000000, periph_irq_priority_a};
			`PIFL_OFS_PRIO_B:  prdata <= {24'h000000, periph_irq_priority_b};
			`PIFL_OFS_CORE:    prdata <= {24'h000000, core_ctrl};
			`PIFL_OFS_EXT:     prdata <= {24'h000000, ext_ctrl};
			`PIFL_OFS_VECTOR:  prdata <= {5'h00, core_prio, ext_pin1_flag, irq_vector};
			default:           prdata <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: bench/pifl_assertions.sv */
// Port-level checker for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module pifl_assertions (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        serial_rx_full,
	input wire logic        serial_tx_empty,
	input wire logic        irq_taken,
	input wire logic        irq_high,
	input wire logic        irq_low,
	input wire logic        wake_request,
	input wire logic [23:0] irq_vector
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Read access phase and refused address decode
	logic rd;
	logic bad;
	assign rd = psel && penable && !pwrite;
	assign bad = paddr > 12'h024 || paddr[1:0] != 2'b00;
	// Core accepting a low request while no high one is pending
	sequence s_take_low;
		irq_taken && irq_low && !irq_high;
	endsequence
	sequence s_low_gone;
		##[1:2] !irq_low;
	endsequence
	a_refused_err: assert property (psel && penable && bad |-> pslverr)
		else $error("no error on refused address");
	a_refused_zero: assert property (rd && bad |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_reset_control_status_gaps_zero: assert property (rd && paddr == 12'h000 |-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'b00 && !prdata[0])
		else $error("reset control gaps not zero");
	a_set_a_top: assert property (rd && (paddr == 12'h004 || paddr == 12'h00c || paddr == 12'h014) |-> prdata[31:7] == 25'h0)
		else $error("first register top bits not zero");
	a_set_b_top: assert property (rd && (paddr == 12'h008 || paddr == 12'h010 || paddr == 12'h018) |-> prdata[31:4] == 28'h0)
		else $error("second register top bits not zero");
	a_rx_live: assert property (rd && paddr == 12'h004 && $stable(serial_rx_full) && $past(serial_rx_full, 2) == serial_rx_full && $past(serial_rx_full, 3) == serial_rx_full |-> prdata[5] == serial_rx_full)
		else $error("receive flag not live");
	a_tx_live: assert property (rd && paddr == 12'h004 && $stable(serial_tx_empty) && $past(serial_tx_empty, 2) == serial_tx_empty && $past(serial_tx_empty, 3) == serial_tx_empty |-> prdata[4] == serial_tx_empty)
		else $error("transmit flag not live");
	a_vector_legal: assert property (irq_vector == 24'h000008 || irq_vector == 24'h000018)
		else $error("vector not one of two");
	a_request_wakes: assert property (irq_high || irq_low |-> wake_request)
		else $error("request without wake");
	a_taken_drops: assert property (s_take_low |-> s_low_gone)
		else $error("low request stays after acceptance");
endmodule
bind pifl_top pifl_assertions u_chk (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .prdata,
	.pslverr, .serial_rx_full, .serial_tx_empty, .irq_taken, .irq_high, .irq_low,
	.wake_request, .irq_vector);
`default_nettype wire

/* File: bench/pifl_core_model.sv */
// Core model that accepts requests and returns after a fixed time
`timescale 1ns/10ps
`default_nettype none
module pifl_core_model #(
	parameter int RET_DELAY = 30
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic irq_high,
	input  wire logic irq_low,
	input  wire logic ack_en,
	output var  logic irq_taken,
	output var  logic irq_return
);
	int cnt;
	// Accept whenever idle and enabled; return pulse re-arms the cleared global enable
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq_taken <= 1'b0;
			irq_return <= 1'b0;
			cnt <= 0;
		end else begin
			irq_taken <= 1'b0;
			irq_return <= 1'b0;
			if (cnt == 0 && ack_en && (irq_high || irq_low)) begin
				irq_taken <= 1'b1;
				cnt <= 1;
			end else if (cnt == RET_DELAY) begin
				irq_return <= 1'b1;
				cnt <= 0;
			end else if (cnt != 0) begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Register-level bench for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, evt;
	logic [31:0] pwdata, prdata, q;
	logic        serial_rx_full, serial_tx_empty, port_b_read, ack_en;
	logic        irq_taken, irq_return, irq_high, irq_low, wake_request;
	logic [1:0]  capcomp_mode_pwm;
	logic [2:0]  ext_pin;
	logic [3:0]  port_b_upper;
	logic [23:0] irq_vector;
	int          n_mismatch = 0, check_count = 0, cyc = 0, n, i;
	int          rv [10] = '{'h1c, 0, 0, 0, 0, 'h7f, 'h0f, 0, 'h7c, 'h6000008};
	int          fa [12] = '{4, 4, 4, 4, 4, 8, 8, 8, 8, 'h1c, 8, 4};
	int          fb [12] = '{6, 3, 2, 1, 0, 3, 2, 1, 0, 2, 0, 2};
	pifl_top u_dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .analog_conv_done(evt[0]), .serial_rx_full, .serial_tx_empty,
		.sync_port_done(evt[1]), .capcomp_mode_pwm, .capcomp_capture_event({evt[10], evt[2]}),
		.capcomp_compare_event({evt[8], evt[11]}), .timer2_period_match(evt[3]),
		.timer1_wrap(evt[4]), .bus_collision(evt[5]), .low_voltage_trip(evt[6]),
		.timer3_wrap(evt[7]), .timer0_wrap(evt[9]), .ext_pin, .port_b_upper, .port_b_read,
		.reset_instruction_evt(1'b0), .watchdog_timeout_evt(1'b0), .power_down_evt(1'b0),
		.irq_taken, .irq_return, .irq_high, .irq_low, .wake_request, .irq_vector);
	pifl_core_model #(.RET_DELAY(30)) u_core (.clock, .nrst, .irq_high, .irq_low, .ack_en,
		.irq_taken, .irq_return);
	////////////////////////////////////////////////////////////////////////////////
	task end_sim;
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One APB transfer; holds the request until pready is seen high
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task wt(input int k);
		repeat (k) @(posedge clock);
	endtask
	task pulse(input int k);
		evt[k] <= 1'b1;
		@(posedge clock);
		evt[k] <= 1'b0;
		@(posedge clock);
	endtask
	// Clock at 4 ns period
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Hang guard well beyond the length of the sequence
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, psel, penable, pwrite, serial_rx_full, serial_tx_empty, port_b_read, ack_en} = 8'h0;
		{paddr, evt, pwdata, capcomp_mode_pwm, ext_pin, port_b_upper} = 65'h0;
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		for (i = 0; i < 10; i++) rd(12'(i * 4), rv[i]);
		rd(12'h028, 32'h0);
		rd(12'h005, 32'h0);
		wr(12'h000, 32'h80);
		rd(12'h000, 32'h80);
		wr(12'h000, 32'h0);
		// Every sticky peripheral and timer0 source with all enables off, then software clear
		for (i = 0; i < 12; i++) begin
			pulse(i);
			rd(12'(fa[i]), 32'h1 << fb[i]);
			wr(12'(fa[i]), 32'h0);
			rd(12'(fa[i]), 32'h0);
		end
		capcomp_mode_pwm <= 2'b11;
		pulse(2);
		pulse(8);
		rd(12'h004, 32'h0);
		rd(12'h008, 32'h0);
		capcomp_mode_pwm <= 2'b00;
		serial_rx_full <= 1'b1;
		serial_tx_empty <= 1'b1;
		wt(4);
		wr(12'h004, 32'h0);
		rd(12'h004, 32'h30);
		serial_rx_full <= 1'b0;
		serial_tx_empty <= 1'b0;
		wt(4);
		rd(12'h004, 32'h0);
		// Compatibility mode request path
		wr(12'h00c, 32'h40);
		pulse(0);
		wt(3);
		chk("wake", 1, wake_request);
		wr(12'h01c, 32'h80);
		wt(3);
		chk("irq_high", 0, irq_high);
		wr(12'h01c, 32'hc0);
		wr(12'h014, 32'h3f);
		wt(3);
		chk("irq_high", 1, irq_high);
		rd(12'h024, 32'h6000008);
		// Priority mode moves the source to the low line
		wr(12'h000, 32'h80);
		wt(3);
		chk("irq_low", 1, irq_low);
		chk("irq_high", 0, irq_high);
		rd(12'h024, 32'h6000018);
		chk("irq_vector", 32'h18, irq_vector);
		ack_en <= 1'b1;
		n = 0;
		while (irq_taken !== 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		ack_en <= 1'b0;
		chk("taken", 1, irq_taken);
		wt(3);
		rd(12'h01c, 32'h80);
		wt(40);
		rd(12'h01c, 32'hc0);
		wr(12'h01c, 32'h0);
		wr(12'h00c, 32'h0);
		wr(12'h004, 32'h0);
		// External pins, both edge selections
		ext_pin[0] <= 1'b1;
		wt(6);
		rd(12'h01c, 32'h2);
		wr(12'h01c, 32'h0);
		wr(12'h020, 32'h6c);
		ext_pin[0] <= 1'b0;
		wt(6);
		rd(12'h01c, 32'h2);
		wr(12'h01c, 32'h0);
		ext_pin[0] <= 1'b1;
		wt(6);
		rd(12'h01c, 32'h0);
		wr(12'h01c, 32'h90);
		ext_pin[0] <= 1'b0;
		wt(6);
		chk("irq_high", 1, irq_high);
		wr(12'h01c, 32'h82);
		wt(3);
		chk("irq_high", 0, irq_high);
		ext_pin[2:1] <= 2'b11;
		wt(6);
		rd(12'h020, 32'hec);
		apb(12'h024, 1'b0, 32'h0);
		chk("pin1 flag", 1, q[24]);
		// Port change after latching the current value
		port_b_read <= 1'b1;
		@(posedge clock);
		port_b_read <= 1'b0;
		wr(12'h01c, 32'h0);
		port_b_upper <= 4'h8;
		wt(6);
		rd(12'h01c, 32'h1);
		// Port change priority bit alone moves the request between lines
		wr(12'h024, 32'h0);
		wr(12'h01c, 32'hc9);
		wt(3);
		chk("irq_low", 1, irq_low);
		chk("irq_high", 0, irq_high);
		wr(12'h024, 32'h4);
		wt(3);
		chk("irq_high", 1, irq_high);
		chk("irq_low", 0, irq_low);
		rd(12'h024, 32'h4000008);
		end_sim();
	end
endmodule
`default_nettype wire
